// ---- hw/mcmr_regs.v ----
// serial command decoder and configuration register of the meter
//
// What this block does
// RULE_01: host opens each transfer with write-only command
// RULE_02: command bits 4..0 address next transfer
// RULE_03: host writes zero to command bits 5,6
// RULE_04: command bit 7: one writes, zero reads
// RULE_05: config bit 0 bypasses channel 1 high-pass
// RULE_06: config bit 1 bypasses post-multiplier low-pass
// RULE_07: config bit 2 stops energy pulse output
// RULE_08: config bit 3 disables sag detection
// RULE_09: config bit 4 powers down both converters
// RULE_10: bit 5 starts temperature conversion, self-clears
// RULE_11: bit 6 soft reset; 18 us quiet
// RULE_12: config bit 7 selects line-cycle accumulation
// RULE_13: config bit 8 shorts channel 1 inputs
// RULE_14: config bit 9 shorts channel 2 inputs
// RULE_15: config bit 10 swaps channel input routing
// RULE_16: bits 12,11 pick update divide 128..1024
// RULE_17: bits 14,13 pick waveform sample source
// RULE_18: config bit 15 enters factory test mode
// RULE_19: config is 16 bits, readable, reset 000Ch
// RULE_20: after data transfer, wait for command again
`timescale 1ns/1ns
`include "mcmr_map.vh"
module mcmr_regs
(
   input  wire        ref_clk,
   input  wire        reset,
   input  wire        spi_sclk,
   input  wire        spi_cs_n,
   input  wire        spi_din,
   output wire        spi_dout,
   output wire        spi_dout_oe,
   input  wire        temp_conv_done,
   output wire        hpf_bypass,
   output wire        post_multiplier_filter_bypass,
   output wire        freq_out_off,
   output wire        sag_detect_off,
   output wire        converter_suspend,
   output wire        temp_convert_start,
   output wire        soft_chip_reset,
   output wire        soft_reset_busy,
   output wire        line_cycle_accum_mode,
   output wire        ch1_input_short,
   output wire        ch2_input_short,
   output wire        input_swap,
   output wire [1:0]  wave_update_rate,
   output wire [1:0]  wave_source_select,
   output wire [5:0]  wave_sample_bits,
   output wire        wave_sample_strobe,
   output wire        factory_test_mode
);

   // transfer states
   localparam [1:0] ST_CMD  = 2'b00;   // shifting in the command byte
   localparam [1:0] ST_DATA = 2'b01;   // shifting register data
   localparam [1:0] ST_HOLD = 2'b10;   // quiet time after a soft reset

   // synchronised pins
   wire        sclk_s;                 // serial clock after two flops
   wire        cs_n_s;                 // chip select after two flops
   wire        din_s;                  // serial data in after two flops

   // edge detection
   reg         sclk_prev_q;            // serial clock one cycle ago
   wire        sclk_fall;              // sample edge
   wire        sclk_rise;              // launch edge
   wire        cs_active;              // chip selected

   // transfer engine
   reg  [1:0]  state_q;                // current transfer state
   reg  [1:0]  state_d;
   reg  [4:0]  bit_cnt_q;              // bits taken in this phase
   reg  [4:0]  bit_cnt_d;
   reg  [15:0] shift_q;                // incoming bit shifter
   reg  [15:0] shift_d;
   reg  [15:0] tx_q;                   // outgoing bit shifter
   reg  [15:0] tx_d;
   reg         dir_wr_q;               // current transfer is a write
   reg         dir_wr_d;
   reg  [4:0]  target_reg_address_q;   // register of current transfer
   reg  [4:0]  target_reg_address_d;
   reg         dout_q;                 // serial data out pin
   reg         dout_d;
   reg         dout_oe_q;              // serial data out enable
   reg         dout_oe_d;
   reg  [11:0] hold_cnt_q;             // soft reset quiet counter
   reg  [11:0] hold_cnt_d;

   // configuration register
   reg  [15:0] cfg_q;                  // live configuration
   reg  [15:0] cfg_d;
   reg         soft_rst_q;             // one-cycle soft reset pulse
   reg         soft_rst_d;

   // waveform rate divider
   reg  [10:0] wave_cnt_q;             // counts master clock cycles
   reg         wave_stb_q;             // one-cycle sample strobe
   reg  [5:0]  wave_bits_q;            // length of current sample
   wire [10:0] wave_div;               // selected divisor

   // helpers for the decoder
   wire [15:0] shift_in;               // shifter with the new bit
   wire [4:0]  data_len;               // data bits for this address
   wire [15:0] read_word;              // value to send on a read

   // bring pins into the clock domain
   mcmr_sync
   #(
      .WIDTH (3)
   )
   u_pin_sync
   (
      .ref_clk  (ref_clk),
      .reset    (reset),
      .async_in ({spi_sclk, spi_cs_n, spi_din}),
      .sync_out ({sclk_s, cs_n_s, din_s})
   );

   // remember previous serial clock level for edge detection
   always @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         sclk_prev_q <= 1'b1;
      end
      else
      begin
         sclk_prev_q <= sclk_s;
      end
   end

   assign sclk_fall = sclk_prev_q & ~sclk_s;
   assign sclk_rise = ~sclk_prev_q & sclk_s;
   assign cs_active = ~cs_n_s;
   assign shift_in  = {shift_q[14:0], din_s};

   // configuration register is 16 bits, all else is one byte
   assign data_len = (target_reg_address_q == `MCMR_CFG_ADDR) ?
                     5'd`MCMR_CFG_WIDTH : 5'd`MCMR_OTHER_WIDTH;

   // read value, right aligned; unmapped addresses read as zero
   assign read_word = (shift_in[`MCMR_CMD_ADDR_MSB:`MCMR_CMD_ADDR_LSB] == `MCMR_CFG_ADDR) ?
                      {cfg_q[15:7], 1'b0, cfg_q[5:0]} : 16'h0000; // RULE_19

   // transfer engine and configuration next state
   always @*
   begin
      state_d              = state_q;
      bit_cnt_d            = bit_cnt_q;
      shift_d              = shift_q;
      tx_d                 = tx_q;
      dir_wr_d             = dir_wr_q;
      target_reg_address_d = target_reg_address_q;
      dout_d               = dout_q;
      dout_oe_d            = dout_oe_q;
      hold_cnt_d           = hold_cnt_q;
      cfg_d                = cfg_q;
      soft_rst_d           = 1'b0;

      // converter finished: hardware clears the start bit
      if (temp_conv_done)
      begin
         cfg_d[`MCMR_TEMP_START_BIT] = 1'b0; // RULE_10
      end

      case (state_q)
         ST_CMD:
         begin
            dout_oe_d = 1'b0;
            if (!cs_active)
            begin
               // deselect drops any partial command
               bit_cnt_d = 5'd0;
            end
            else if (sclk_fall)
            begin
               shift_d   = shift_in;
               bit_cnt_d = bit_cnt_q + 5'd1;
               // eighth bit closes the command byte
               if (bit_cnt_q == 5'd7) // RULE_01
               begin
                  dir_wr_d             = shift_in[`MCMR_CMD_DIR_BIT]; // RULE_04
                  target_reg_address_d = shift_in[`MCMR_CMD_ADDR_MSB:`MCMR_CMD_ADDR_LSB]; // RULE_02
                  bit_cnt_d            = 5'd0;
                  state_d              = ST_DATA;
                  // bits 5 and 6 carry nothing and are ignored  RULE_03
                  if (!shift_in[`MCMR_CMD_DIR_BIT])
                  begin
                     // read: first bit out at once, rest on rising edges
                     if (shift_in[`MCMR_CMD_ADDR_MSB:`MCMR_CMD_ADDR_LSB] == `MCMR_CFG_ADDR)
                     begin
                        dout_d = read_word[15];
                        tx_d   = {read_word[14:0], 1'b0};
                     end
                     else
                     begin
                        dout_d = read_word[7];
                        tx_d   = {read_word[6:0], 9'h000};
                     end
                     dout_oe_d = 1'b1;
                  end
               end
            end
         end

         ST_DATA:
         begin
            if (!cs_active)
            begin
               // deselect aborts; nothing is written
               bit_cnt_d = 5'd0;
               dout_oe_d = 1'b0;
               state_d   = ST_CMD;
            end
            else if (sclk_fall)
            begin
               shift_d   = shift_in;
               bit_cnt_d = bit_cnt_q + 5'd1;
               if (bit_cnt_q == data_len - 5'd1)
               begin
                  // transfer done, back to command wait
                  bit_cnt_d = 5'd0;
                  dout_oe_d = 1'b0;
                  state_d   = ST_CMD; // RULE_20
                  if (dir_wr_q && (target_reg_address_q == `MCMR_CFG_ADDR))
                  begin
                     if (shift_in[`MCMR_SOFT_RST_BIT])
                     begin
                        // soft reset restores defaults and starts quiet time
                        cfg_d      = `MCMR_CFG_RESET; // RULE_11
                        soft_rst_d = 1'b1;
                        hold_cnt_d = 12'd0;
                        state_d    = ST_HOLD;
                     end
                     else
                     begin
                        // a write of the start bit wins over a done pulse
                        cfg_d = shift_in; // RULE_05 RULE_06 RULE_07 RULE_08 RULE_09 RULE_10
                     end
                  end
               end
            end
            else if (sclk_rise && !dir_wr_q && (bit_cnt_q != 5'd0))
            begin
               // launch next read bit
               dout_d = tx_q[15];
               tx_d   = {tx_q[14:0], 1'b0};
            end
         end

         ST_HOLD:
         begin
            // serial port ignored until the quiet time ends
            dout_oe_d = 1'b0;
            bit_cnt_d = 5'd0;
            if (hold_cnt_q == `MCMR_SOFT_CHIP_RESET_HOLD_CYC - 12'd1) // RULE_11
            begin
               state_d = ST_CMD;
            end
            else
            begin
               hold_cnt_d = hold_cnt_q + 12'd1;
            end
         end

         default:
         begin
            state_d   = ST_CMD;
            bit_cnt_d = 5'd0;
            dout_oe_d = 1'b0;
         end
      endcase
   end

   // transfer and configuration registers
   always @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         state_q              <= ST_CMD;
         bit_cnt_q            <= 5'd0;
         shift_q              <= 16'h0000;
         tx_q                 <= 16'h0000;
         dir_wr_q             <= 1'b0;
         target_reg_address_q <= 5'h00;
         dout_q               <= 1'b0;
         dout_oe_q            <= 1'b0;
         hold_cnt_q           <= 12'h000;
         cfg_q                <= `MCMR_CFG_RESET; // RULE_19
         soft_rst_q           <= 1'b0;
      end
      else
      begin
         state_q              <= state_d;
         bit_cnt_q            <= bit_cnt_d;
         shift_q              <= shift_d;
         tx_q                 <= tx_d;
         dir_wr_q             <= dir_wr_d;
         target_reg_address_q <= target_reg_address_d;
         dout_q               <= dout_d;
         dout_oe_q            <= dout_oe_d;
         hold_cnt_q           <= hold_cnt_d;
         cfg_q                <= cfg_d;
         soft_rst_q           <= soft_rst_d;
      end
   end

   // divisor is 128 shifted left by the rate code
   assign wave_div = `MCMR_WAVE_DIV_BASE << cfg_q[`MCMR_RATE_MSB:`MCMR_RATE_LSB]; // RULE_16

   // waveform update strobe and sample length
   always @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         wave_cnt_q  <= 11'h000;
         wave_stb_q  <= 1'b0;
         wave_bits_q <= `MCMR_WAVE_LEN_SHORT;
      end
      else
      begin
         // a rate change to a shorter period restarts a count already past its end
         if (wave_cnt_q >= wave_div - 11'd1)
         begin
            wave_cnt_q <= 11'h000;
            wave_stb_q <= 1'b1; // RULE_16
         end
         else
         begin
            wave_cnt_q <= wave_cnt_q + 11'd1;
            wave_stb_q <= 1'b0;
         end
         // both channels together make the long sample
         if (cfg_q[`MCMR_SRC_MSB:`MCMR_SRC_LSB] == `MCMR_SRC_BOTH)
         begin
            wave_bits_q <= `MCMR_WAVE_LEN_LONG; // RULE_17
         end
         else
         begin
            wave_bits_q <= `MCMR_WAVE_LEN_SHORT; // RULE_17
         end
      end
   end

   // outputs straight from flip-flops
   assign spi_dout                      = dout_q;
   assign spi_dout_oe                   = dout_oe_q;
   assign hpf_bypass                    = cfg_q[`MCMR_HPF_BYP_BIT];    // RULE_05
   assign post_multiplier_filter_bypass = cfg_q[`MCMR_LPF_BYP_BIT];    // RULE_06
   assign freq_out_off                  = cfg_q[`MCMR_FREQ_OFF_BIT];   // RULE_07
   assign sag_detect_off                = cfg_q[`MCMR_SAG_OFF_BIT];    // RULE_08
   assign converter_suspend             = cfg_q[`MCMR_SUSPEND_BIT];    // RULE_09
   assign temp_convert_start            = cfg_q[`MCMR_TEMP_START_BIT]; // RULE_10
   assign soft_chip_reset               = soft_rst_q;                  // RULE_11
   assign soft_reset_busy               = state_q[1];   // only the hold state has bit 1 set
   assign line_cycle_accum_mode         = cfg_q[`MCMR_CYC_MODE_BIT];   // RULE_12
   assign ch1_input_short               = cfg_q[`MCMR_CH1_SHORT_BIT];  // RULE_13
   assign ch2_input_short               = cfg_q[`MCMR_CH2_SHORT_BIT];  // RULE_14
   assign input_swap                    = cfg_q[`MCMR_SWAP_BIT];       // RULE_15
   assign wave_update_rate              = cfg_q[`MCMR_RATE_MSB:`MCMR_RATE_LSB];
   assign wave_source_select            = cfg_q[`MCMR_SRC_MSB:`MCMR_SRC_LSB]; // RULE_17
   assign wave_sample_bits              = wave_bits_q;
   assign wave_sample_strobe            = wave_stb_q;
   assign factory_test_mode             = cfg_q[`MCMR_TEST_BIT];       // RULE_18

endmodule // mcmr_regs

// ---- hw/mcmr_map.vh ----
// constants for the meter command and mode register block
`ifndef MCMR_MAP_VH
`define MCMR_MAP_VH

// command byte layout
`define MCMR_CMD_WIDTH        8
`define MCMR_CMD_DIR_BIT      7
`define MCMR_CMD_ADDR_MSB     4
`define MCMR_CMD_ADDR_LSB     0

// register address and width of the configuration register
`define MCMR_CFG_ADDR         5'h06
`define MCMR_CFG_WIDTH        16
`define MCMR_CFG_RESET        16'h000C
// width of a transfer to any other address
`define MCMR_OTHER_WIDTH      8

// configuration field positions
`define MCMR_HPF_BYP_BIT      0
`define MCMR_LPF_BYP_BIT      1
`define MCMR_FREQ_OFF_BIT     2
`define MCMR_SAG_OFF_BIT      3
`define MCMR_SUSPEND_BIT      4
`define MCMR_TEMP_START_BIT   5
`define MCMR_SOFT_RST_BIT     6
`define MCMR_CYC_MODE_BIT     7
`define MCMR_CH1_SHORT_BIT    8
`define MCMR_CH2_SHORT_BIT    9
`define MCMR_SWAP_BIT         10
`define MCMR_RATE_MSB         12
`define MCMR_RATE_LSB         11
`define MCMR_SRC_MSB          14
`define MCMR_SRC_LSB          13
`define MCMR_TEST_BIT         15

// waveform rate divider base and sample lengths
`define MCMR_WAVE_DIV_BASE    11'h080
`define MCMR_WAVE_LEN_SHORT   6'h18
`define MCMR_WAVE_LEN_LONG    6'h28
`define MCMR_SRC_BOTH         2'h1

// timing: hold-off after a soft reset, 18 us at 10 ns per clock
`define MCMR_SOFT_CHIP_RESET_HOLD_CYC   12'd1800

`endif

// ---- hw/mcmr_sync.v ----
// two-stage synchroniser for pin inputs
`timescale 1ns/1ns
module mcmr_sync
#(
   parameter WIDTH = 1
)
(
   input  wire             ref_clk,
   input  wire             reset,
   input  wire [WIDTH-1:0] async_in,
   output wire [WIDTH-1:0] sync_out
);

   reg [WIDTH-1:0] meta_q;   // first stage, read only by second stage
   reg [WIDTH-1:0] sync_q;   // second stage, safe to use

   // both stages reset high so idle pins look inactive
   always @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         meta_q <= {WIDTH{1'b1}};
         sync_q <= {WIDTH{1'b1}};
      end
      else
      begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end

   assign sync_out = sync_q;

endmodule // mcmr_sync

// ---- dv/mcmr_props.sv ----
// port assertions for the command and mode register block
`timescale 1ns/1ns
module mcmr_props
(
   input wire       ref_clk,
   input wire       reset,
   input wire       spi_cs_n,
   input wire       spi_dout_oe,
   input wire       temp_conv_done,
   input wire       temp_convert_start,
   input wire       soft_chip_reset,
   input wire       soft_reset_busy,
   input wire       freq_out_off,
   input wire       sag_detect_off,
   input wire       factory_test_mode,
   input wire [1:0] wave_update_rate,
   input wire [1:0] wave_source_select,
   input wire [5:0] wave_sample_bits,
   input wire       wave_sample_strobe
);
   reg [10:0] busy_q;  // length of the quiet time so far
   reg [10:0] gap_q;   // clocks since the last strobe
   reg        chg_q;   // rate or reset disturbed this window
   reg [1:0]  rate_q;  // rate one clock ago
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);
   // counters for spans too long to unroll
   always @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         busy_q <= 11'h000;
         gap_q  <= 11'h000;
         chg_q  <= 1'b1;
         rate_q <= 2'h0;
      end
      else
      begin
         busy_q <= soft_reset_busy ? busy_q + 11'h001 : 11'h000;
         gap_q  <= wave_sample_strobe ? 11'h000 : gap_q + 11'h001;
         chg_q  <= (chg_q & ~wave_sample_strobe) | soft_reset_busy | soft_chip_reset
                   | (rate_q != wave_update_rate);
         rate_q <= wave_update_rate;
      end
   end
   reset_config_a: assert property ($fell(reset) |-> freq_out_off && sag_detect_off
      && !factory_test_mode && wave_source_select == 2'h0) else $error("bad reset config");
   busy_len_a: assert property ($fell(soft_reset_busy) |-> busy_q == 11'h708)
      else $error("quiet time length wrong");
   srst_pulse_a: assert property (soft_chip_reset |=> !soft_chip_reset && soft_reset_busy)
      else $error("soft reset pulse wrong");
   srst_config_a: assert property (soft_chip_reset |-> ##[0:1] freq_out_off
      && sag_detect_off && wave_update_rate == 2'h0) else $error("soft reset config wrong");
   sample_len_a: assert property ($stable(wave_source_select) |-> wave_sample_bits
      == (wave_source_select == 2'h1 ? 6'h28 : 6'h18)) else $error("sample length wrong");
   strobe_gap_a: assert property (wave_sample_strobe && !chg_q
      && rate_q == wave_update_rate |-> gap_q == ((11'h080 << wave_update_rate) - 11'h001))
      else $error("strobe spacing wrong");
   temp_clear_a: assert property (spi_cs_n && temp_conv_done && temp_convert_start |=> !temp_convert_start)
      else $error("temperature start not cleared");
   oe_idle_a: assert property (spi_cs_n [*6] |-> !spi_dout_oe)
      else $error("output driven outside a frame");
   srst_seen_c: cover property (soft_chip_reset);
   read_seen_c: cover property ($rose(spi_dout_oe));
   slow_rate_c: cover property (wave_sample_strobe && !chg_q && wave_update_rate == 2'h3);
endmodule // mcmr_props
bind mcmr_regs mcmr_props mcmr_props_inst
(
   .ref_clk(ref_clk), .reset(reset), .spi_cs_n(spi_cs_n), .spi_dout_oe(spi_dout_oe),
   .temp_conv_done(temp_conv_done), .temp_convert_start(temp_convert_start),
   .soft_chip_reset(soft_chip_reset), .soft_reset_busy(soft_reset_busy),
   .freq_out_off(freq_out_off), .sag_detect_off(sag_detect_off),
   .factory_test_mode(factory_test_mode), .wave_update_rate(wave_update_rate),
   .wave_source_select(wave_source_select), .wave_sample_bits(wave_sample_bits),
   .wave_sample_strobe(wave_sample_strobe)
);

// ---- dv/mcmr_host.sv ----
// host model driving the serial link
`timescale 1ns/1ns
module mcmr_host
(
   input  wire ref_clk,
   output reg  spi_sclk,
   output reg  spi_cs_n,
   output reg  spi_din,
   input  wire spi_dout,
   input  wire spi_dout_oe
);
   localparam HALF = 6;  // clocks per sclk level, above the 3 needed
   // idle link: clock high and still, not selected
   initial
   begin
      spi_sclk = 1'b1;
      spi_cs_n = 1'b1;
      spi_din  = 1'b0;
   end
   // one frame: command byte, then nd data bits, msb first
   task automatic xfer(input [7:0] cmd, input [15:0] wd, input integer nd,
                       output [15:0] rd);
      reg [23:0] sh;
      integer    i;
      begin
         sh = {cmd, wd << (16 - nd)};
         rd = 16'h0000;
         spi_cs_n <= 1'b0;
         for (i = 0; i < 8 + nd; i = i + 1)
         begin
            spi_din <= sh[23];  // data settles while clock is high
            sh = sh << 1;
            repeat (HALF) @(posedge ref_clk);
            if (i >= 8)
               rd = {rd[14:0], spi_dout_oe & spi_dout};  // taken before the fall
            spi_sclk <= 1'b0;
            repeat (HALF) @(posedge ref_clk);
            spi_sclk <= 1'b1;
         end
         repeat (HALF) @(posedge ref_clk);
         spi_cs_n <= 1'b1;
         spi_din  <= ~spi_din;  // released line keeps no stale value
         repeat (HALF) @(posedge ref_clk);
      end
   endtask
endmodule // mcmr_host

// ---- dv/mcmr_regs_tb.sv ----
// self-checking bench for the command and mode register block
`timescale 1ns/1ns
`define CHK(a, e) \
   begin \
      tests_run = tests_run + 1; \
      if ((a) !== (e)) \
      begin \
         failures = failures + 1; \
         $display("unexpected at %0t: got %h expected %h", $time, a, e); \
      end \
   end
module mcmr_regs_tb;
   reg         ref_clk, reset, temp_conv_done;
   reg         vld;       // a transfer result is ready
   reg  [15:0] got_rd;    // data the host read back
   reg  [15:0] cfg;       // expected configuration
   reg  [31:0] exp_q[$];  // expected {config, read data}
   reg  [31:0] e;
   reg  [15:0] d;
   integer     failures, tests_run, k;
   wire        spi_sclk, spi_cs_n, spi_din, spi_dout, spi_dout_oe;
   wire        hpf_bypass, post_multiplier_filter_bypass, freq_out_off, sag_detect_off;
   wire        converter_suspend, temp_convert_start, line_cycle_accum_mode;
   wire        ch1_input_short, ch2_input_short, input_swap, factory_test_mode;
   wire [1:0]  wave_update_rate, wave_source_select;
   wire [15:0] obs = {factory_test_mode, wave_source_select, wave_update_rate, input_swap,
                      ch2_input_short, ch1_input_short, line_cycle_accum_mode, 1'b0,
                      temp_convert_start, converter_suspend, sag_detect_off, freq_out_off,
                      post_multiplier_filter_bypass, hpf_bypass};
   mcmr_regs mcmr_regs_inst
   (
      .ref_clk(ref_clk), .reset(reset), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
      .spi_din(spi_din), .spi_dout(spi_dout), .spi_dout_oe(spi_dout_oe),
      .temp_conv_done(temp_conv_done), .hpf_bypass(hpf_bypass),
      .post_multiplier_filter_bypass(post_multiplier_filter_bypass),
      .freq_out_off(freq_out_off), .sag_detect_off(sag_detect_off),
      .converter_suspend(converter_suspend), .temp_convert_start(temp_convert_start),
      .soft_chip_reset(), .soft_reset_busy(), .input_swap(input_swap),
      .line_cycle_accum_mode(line_cycle_accum_mode), .ch1_input_short(ch1_input_short),
      .ch2_input_short(ch2_input_short), .wave_update_rate(wave_update_rate),
      .wave_source_select(wave_source_select), .wave_sample_bits(),
      .wave_sample_strobe(), .factory_test_mode(factory_test_mode)
   );
   mcmr_host mcmr_host_inst
   (
      .ref_clk(ref_clk), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_din(spi_din),
      .spi_dout(spi_dout), .spi_dout_oe(spi_dout_oe)
   );
   // 100 MHz clock
   always #5 ref_clk = ~ref_clk;
   // one transfer, its expected outcome noted first
   task automatic run(input [7:0] cmd, input [15:0] wd, input integer nd,
                      input [15:0] ecfg, input [15:0] erd);
      reg [15:0] rd;
      begin
         exp_q.push_back({ecfg, erd});
         mcmr_host_inst.xfer(cmd, wd, nd, rd);
         got_rd <= rd;
         vld    <= 1'b1;
         @(posedge ref_clk);
         vld    <= 1'b0;
      end
   endtask
   // configuration write; bit 6 is never stored
   task automatic wr(input [15:0] wd);
      begin
         cfg = wd & 16'hFFBF;
         run(8'h86, wd, 16, cfg, 16'h0000);
      end
   endtask
   // configuration read
   task automatic rd6;
      begin
         run(8'h06, 16'h0000, 16, cfg, cfg);
      end
   endtask
   // prints the counts and the verdict, then stops
   task results;
      begin
         $display("comparisons %0d mismatches %0d", tests_run, failures);
         if (failures == 0 && tests_run > 0)
            $display("No errors found");
         else
            $display("Errors were found");
         $finish;
      end
   endtask
   // takes the oldest note whenever a transfer result appears
   always @(posedge ref_clk)
   begin
      if (vld)
      begin
         e = exp_q.pop_front();
         `CHK({obs, got_rd}, e)
      end
   end
   // cuts a hang short
   initial
   begin
      repeat (40000) @(posedge ref_clk);
      failures = failures + 1;
      results;
   end
   // reset, then the scenarios in turn
   initial
   begin
      ref_clk = 1'b0;
      reset = 1'b1;
      temp_conv_done = 1'b0;
      vld = 1'b0;
      got_rd = 16'h0000;
      failures = 0;
      tests_run = 0;
      cfg = 16'h000C;
      d = $urandom(13);
      repeat (12) @(posedge ref_clk);
      reset <= 1'b0;
      repeat (4) @(posedge ref_clk);
      rd6;
      $display("test reset done");
      for (k = 0; k < 8; k = k + 1)
      begin
         d = $urandom;
         d[15] = 1'b0;
         d[6] = 1'b0;
         d[14:11] = {k[1:0], k[1:0]};
         wr(d);
         rd6;
      end
      $display("test fields done");
      run(8'h8A, 16'h00A5, 8, cfg, 16'h0000);
      run(8'h96, 16'h00FF, 8, cfg, 16'h0000);
      run(8'h16, 16'h0000, 8, cfg, 16'h0000);
      run(8'h86, 16'h1234, 12, cfg, 16'h0000);
      rd6;
      $display("test address and abort done");
      cfg = 16'h8000;
      run(8'hE6, 16'h8000, 16, cfg, 16'h0000);
      run(8'h66, 16'h0000, 16, cfg, cfg);
      $display("test command field done");
      wr(16'h0020);
      temp_conv_done <= 1'b1;
      @(posedge ref_clk);
      temp_conv_done <= 1'b0;
      cfg = 16'h0000;
      rd6;
      $display("test temperature done");
      run(8'h86, 16'h00C1, 16, 16'h000C, 16'h0000);
      run(8'h86, 16'h0080, 16, 16'h000C, 16'h0000);
      cfg = 16'h000C;
      repeat (1810) @(posedge ref_clk);
      rd6;
      $display("test soft reset done");
      results;
   end
endmodule // mcmr_regs_tb
